// ===== pit_timer_pkg.sv
// Shared constants for the parallel interface timer block.
package pit_timer_pkg;
    localparam int COUNT_W = 24;
    localparam int PRE_W   = 5;
    localparam int ADDR_W  = 8;

    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_PRELOAD = 8'h08;
    localparam logic [7:0] OFF_COUNT   = 8'h0C;
    localparam logic [7:0] OFF_VECTOR  = 8'h10;
    localparam logic [7:0] OFF_PC_DATA = 8'h14;
    localparam logic [7:0] OFF_PC_DIR  = 8'h18;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CLK_LSB  = 1;
    localparam int CTRL_ZD_BIT   = 4;
    localparam int CTRL_TACK_BIT = 5;
    localparam int CTRL_FUNC_LSB = 6;
    localparam int STATUS_ZD_BIT = 0;
    localparam int PC_BIT        = 3;

    localparam logic [1:0] CLK_PRE    = 2'h0;
    localparam logic [1:0] CLK_GATED  = 2'h1;
    localparam logic [1:0] CLK_TINPRE = 2'h2;
    localparam logic [1:0] CLK_TINDIR = 2'h3;

    localparam logic [1:0] FUNC_PORT   = 2'h0;
    localparam logic [1:0] FUNC_SQUARE = 2'h1;

    localparam logic [7:0]       CTRL_RESET   = 8'h00;
    localparam logic [7:0]       VECTOR_RESET = 8'h0F;
    localparam logic [PRE_W-1:0] PRE_ONES     = 5'h1F;
    localparam logic [COUNT_W-1:0] COUNT_ONE  = 24'h000001;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONES = 24'hFFFFFF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== pit_prescaler.sv
// Five-bit divide-by-32 prescaler with halt forcing.
`timescale 1ns/100ps
module pit_prescaler
(
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    input  wire logic force_in,
    input  wire logic step_in,
    output logic      tick_out
);
    typedef struct packed {
        logic [pit_timer_pkg::PRE_W-1:0] count;
    } pre_state_t;

    pre_state_t state;
    pre_state_t next_state;

    // A tick marks the pass from zero to all ones.
    assign tick_out = step_in && !force_in && (state.count == '0);

    always_comb
    begin
        next_state = state;
        if (force_in)
        begin
            next_state.count = pit_timer_pkg::PRE_ONES;
        end
        else if (step_in)
        begin
            next_state.count = state.count - 5'h01;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state.count <= pit_timer_pkg::PRE_ONES;
        end
        else
        begin
            state <= next_state;
        end
    end

    a_force_to_ones : assert property (@(posedge clock_in) disable iff (!rst_b_in)
        force_in |=> state.count == pit_timer_pkg::PRE_ONES)
        else $error("Prescaler not forced to all ones.");

    a_divide_by_32 : assert property (@(posedge clock_in) disable iff (!rst_b_in)
        tick_out |=> state.count == pit_timer_pkg::PRE_ONES)
        else $error("Prescaler tick not followed by reload.");
endmodule

// ===== pit_axil_slave.sv
// AXI4-Lite slave front end for the timer registers.
`timescale 1ns/100ps
module pit_axil_slave
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic             wr_en_out,
    output logic [7:0]       wr_addr_out,
    output logic [31:0]      wr_data_out,
    output logic [3:0]       wr_strb_out,
    input  wire logic        wr_err_in,
    output logic [7:0]       rd_addr_out,
    input  wire logic [31:0] rd_data_in,
    input  wire logic        rd_err_in
);
    typedef struct packed {
        logic        aw_held;
        logic        w_held;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } slave_state_t;

    slave_state_t state;
    slave_state_t next_state;

    assign s_axi_awready_out = !state.aw_held && !state.bvalid;
    assign s_axi_wready_out  = !state.w_held && !state.bvalid;
    assign s_axi_arready_out = !state.rvalid;
    assign s_axi_bvalid_out  = state.bvalid;
    assign s_axi_bresp_out   = state.bresp;
    assign s_axi_rvalid_out  = state.rvalid;
    assign s_axi_rdata_out   = state.rdata;
    assign s_axi_rresp_out   = state.rresp;
    assign wr_en_out   = state.aw_held && state.w_held && !state.bvalid;
    assign wr_addr_out = state.awaddr;
    assign wr_data_out = state.wdata;
    assign wr_strb_out = state.wstrb;
    assign rd_addr_out = s_axi_araddr_in;

    always_comb
    begin
        next_state = state;
        if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            next_state.aw_held = 1'b1;
            next_state.awaddr  = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            next_state.w_held = 1'b1;
            next_state.wdata  = s_axi_wdata_in;
            next_state.wstrb  = s_axi_wstrb_in;
        end
        if (wr_en_out)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = wr_err_in ? pit_timer_pkg::RESP_SLVERR : pit_timer_pkg::RESP_OKAY;
        end
        else if (state.bvalid && s_axi_bready_in)
        begin
            next_state.bvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = rd_data_in;
            next_state.rresp  = rd_err_in ? pit_timer_pkg::RESP_SLVERR : pit_timer_pkg::RESP_OKAY;
        end
        else if (state.rvalid && s_axi_rready_in)
        begin
            next_state.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end
endmodule

// ===== pit_timer.sv
// Top level of the 24-bit down-counting timer with its pin and bus logic.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
// Functional notes
// - Counter step from one to zero sets zero-detect flag and asserts output.
// - Zero-detect control clear: next counter clock reloads preload, then decrements.
// - Square wave mode toggles the output pin on each zero detect.
// - Port C data read returns the present output pin level.
// - Square wave mode holds the output pin high until enabled.
// - After reset the shared pin is port C bit 3 until selected.
// - Acknowledge answered with vector only while interrupt request asserted.
// - Zero-detect control set: counter rolls over instead of reloading.
// - Elapsed time mode: external input starts and stops counting.
// - Event counting decrements on external input pulses while running.
// - Watchdog mode: once enabled, external input controls run and halt.
// - Watchdog: input high loads preload into counter and starts counting.
// - Watchdog: input falling before zero keeps output and flag negated.
// - Watchdog: zero while input high sets flag, asserts output, rolls over.
// - Watchdog: input low clears flag, negates output, stops, prescaler ones.
// - Status write with bit 0 set clears flag, winning over zero detect.
// - Counter clocked by input directly or by divide-by-32 prescaler.
// - Reset clears the whole control register, disabling the timer.
module pit_timer
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        timer_ext_input_pin_in,
    input  wire logic        timer_out_pin_in,
    output logic             timer_out_pin_out,
    output logic             timer_out_pin_oe_out,
    input  wire logic        timer_irq_ack_pin_in,
    output logic             transfer_acknowledge_out,
    output logic [7:0]       ack_vector_out
);
    typedef struct packed {
        logic [7:0]  timer_control;
        logic [23:0] preload_value;
        logic [23:0] count;
        logic        zero_detect_flag;
        logic        square;
        logic        load_pending;
        logic        tin_prev;
        logic [7:0]  vector;
        logic        pc_data;
        logic        pc_dir;
        logic        ack;
        logic [7:0]  ack_vector;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;

    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic [1:0]  clk_sel;
    logic [1:0]  pin_func;
    logic        enabled;
    logic        irq_mode;
    logic        run;
    logic        tin_rise;
    logic        pre_step;
    logic        pre_tick;
    logic        tick;
    logic        zero_hit;
    logic        status_clear;
    logic [31:0] ctrl_word, preload_word, vector_word;

    // Merges the written bytes into an existing register word.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        return addr == pit_timer_pkg::OFF_CTRL || addr == pit_timer_pkg::OFF_STATUS
            || addr == pit_timer_pkg::OFF_PRELOAD || addr == pit_timer_pkg::OFF_COUNT
            || addr == pit_timer_pkg::OFF_VECTOR || addr == pit_timer_pkg::OFF_PC_DATA
            || addr == pit_timer_pkg::OFF_PC_DIR;
    endfunction

    pit_axil_slave bus
    (
        .clock_in          (clock_in),
        .rst_b_in          (rst_b_in),
        .s_axi_awaddr_in   (s_axi_awaddr_in),
        .s_axi_awvalid_in  (s_axi_awvalid_in),
        .s_axi_awready_out (s_axi_awready_out),
        .s_axi_wdata_in    (s_axi_wdata_in),
        .s_axi_wstrb_in    (s_axi_wstrb_in),
        .s_axi_wvalid_in   (s_axi_wvalid_in),
        .s_axi_wready_out  (s_axi_wready_out),
        .s_axi_bresp_out   (s_axi_bresp_out),
        .s_axi_bvalid_out  (s_axi_bvalid_out),
        .s_axi_bready_in   (s_axi_bready_in),
        .s_axi_araddr_in   (s_axi_araddr_in),
        .s_axi_arvalid_in  (s_axi_arvalid_in),
        .s_axi_arready_out (s_axi_arready_out),
        .s_axi_rdata_out   (s_axi_rdata_out),
        .s_axi_rresp_out   (s_axi_rresp_out),
        .s_axi_rvalid_out  (s_axi_rvalid_out),
        .s_axi_rready_in   (s_axi_rready_in),
        .wr_en_out         (wr_en),
        .wr_addr_out       (wr_addr),
        .wr_data_out       (wr_data),
        .wr_strb_out       (wr_strb),
        .wr_err_in         (!addr_mapped(wr_addr)),
        .rd_addr_out       (rd_addr),
        .rd_data_in        (rd_data),
        .rd_err_in         (!addr_mapped(rd_addr))
    );

    pit_prescaler prescaler
    (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .force_in (!run),
        .step_in  (pre_step),
        .tick_out (pre_tick)
    );

    assign clk_sel  = state.timer_control[pit_timer_pkg::CTRL_CLK_LSB +: 2];
    assign pin_func = state.timer_control[pit_timer_pkg::CTRL_FUNC_LSB +: 2];
    assign enabled  = state.timer_control[pit_timer_pkg::CTRL_EN_BIT];
    assign irq_mode = pin_func[1];
    assign tin_rise = timer_ext_input_pin_in && !state.tin_prev;

    // In gated mode the external input is the run/halt control.
    assign run = enabled && (clk_sel != pit_timer_pkg::CLK_GATED || timer_ext_input_pin_in);

    // The prescaler runs from the clock, or from input edges in mode two.
    assign pre_step = run && (clk_sel == pit_timer_pkg::CLK_TINPRE ? tin_rise
                                                                   : clk_sel != pit_timer_pkg::CLK_TINDIR);

    assign tick = clk_sel == pit_timer_pkg::CLK_TINDIR ? run && tin_rise : pre_tick;

    assign zero_hit = tick && !state.load_pending && state.count == pit_timer_pkg::COUNT_ONE;

    assign status_clear = wr_en && wr_addr == pit_timer_pkg::OFF_STATUS && wr_strb[0]
                          && wr_data[pit_timer_pkg::STATUS_ZD_BIT];

    assign ctrl_word    = merge_bytes(32'(state.timer_control), wr_data, wr_strb);
    assign preload_word = merge_bytes(32'(state.preload_value), wr_data, wr_strb);
    assign vector_word  = merge_bytes(32'(state.vector), wr_data, wr_strb);

    always_comb
    begin
        next_state = state;
        next_state.tin_prev = timer_ext_input_pin_in;

        // Halt keeps the count, clears the flag and arms the first-tick load.
        if (!run)
        begin
            next_state.zero_detect_flag = 1'b0;
            next_state.load_pending     = 1'b1;
        end
        else if (tick)
        begin
            if (state.load_pending)
            begin
                next_state.count        = state.preload_value;
                next_state.load_pending = 1'b0;
            end
            else if (state.count == pit_timer_pkg::COUNT_ZERO
                     && !state.timer_control[pit_timer_pkg::CTRL_ZD_BIT])
            begin
                next_state.count = state.preload_value;
            end
            else
            begin
                next_state.count = state.count - pit_timer_pkg::COUNT_ONE;
            end
        end

        if (zero_hit)
        begin
            next_state.zero_detect_flag = 1'b1;
            if (pin_func == pit_timer_pkg::FUNC_SQUARE)
            begin
                next_state.square = !state.square;
            end
        end

        // The direct clear is applied last so it wins over a zero detect.
        if (status_clear)
        begin
            next_state.zero_detect_flag = 1'b0;
        end

        if (!enabled)
        begin
            next_state.square = 1'b1;
        end

        if (wr_en)
        begin
            unique case (wr_addr)
                pit_timer_pkg::OFF_CTRL:
                begin
                    next_state.timer_control = ctrl_word[7:0];
                end
                pit_timer_pkg::OFF_PRELOAD:
                begin
                    next_state.preload_value = preload_word[23:0];
                end
                pit_timer_pkg::OFF_VECTOR:
                begin
                    next_state.vector = vector_word[7:0];
                end
                pit_timer_pkg::OFF_PC_DATA:
                begin
                    if (wr_strb[0])
                    begin
                        next_state.pc_data = wr_data[pit_timer_pkg::PC_BIT];
                    end
                end
                pit_timer_pkg::OFF_PC_DIR:
                begin
                    if (wr_strb[0])
                    begin
                        next_state.pc_dir = wr_data[pit_timer_pkg::PC_BIT];
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Acknowledge is answered only while the request is really asserted.
        next_state.ack = timer_irq_ack_pin_in && irq_mode && state.zero_detect_flag
                         && state.timer_control[pit_timer_pkg::CTRL_TACK_BIT];
        next_state.ack_vector = next_state.ack ? state.vector : 8'h00;
    end

    always_comb
    begin
        rd_data = 32'h00000000;
        unique case (rd_addr)
            pit_timer_pkg::OFF_CTRL:    rd_data[7:0]  = state.timer_control;
            pit_timer_pkg::OFF_STATUS:  rd_data[0]    = state.zero_detect_flag;
            pit_timer_pkg::OFF_PRELOAD: rd_data[23:0] = state.preload_value;
            pit_timer_pkg::OFF_COUNT:   rd_data[23:0] = state.count;
            pit_timer_pkg::OFF_VECTOR:  rd_data[7:0]  = state.vector;
            pit_timer_pkg::OFF_PC_DATA: rd_data[pit_timer_pkg::PC_BIT] = timer_out_pin_in;
            pit_timer_pkg::OFF_PC_DIR:  rd_data[pit_timer_pkg::PC_BIT] = state.pc_dir;
            default:                    rd_data = 32'h00000000;
        endcase
    end

    // Pin mux: port bit after reset, else square wave or interrupt request.
    always_comb
    begin
        unique case (pin_func)
            pit_timer_pkg::FUNC_PORT:
            begin
                timer_out_pin_out    = state.pc_data;
                timer_out_pin_oe_out = state.pc_dir;
            end
            pit_timer_pkg::FUNC_SQUARE:
            begin
                timer_out_pin_out    = enabled ? state.square : 1'b1;
                timer_out_pin_oe_out = 1'b1;
            end
            default:
            begin
                timer_out_pin_out    = state.zero_detect_flag;
                timer_out_pin_oe_out = 1'b1;
            end
        endcase
    end

    assign transfer_acknowledge_out = state.ack;
    assign ack_vector_out           = state.ack_vector;

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state               <= '0;
            state.timer_control <= pit_timer_pkg::CTRL_RESET;
            state.square        <= 1'b1;
            state.load_pending  <= 1'b1;
            state.vector        <= pit_timer_pkg::VECTOR_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    a_zero_sets_flag : assert property (zero_hit && !status_clear |=> state.zero_detect_flag)
        else $error("Zero detect did not set the flag.");

    a_reload_after_zero : assert property (
        run && tick && !state.load_pending && state.count == pit_timer_pkg::COUNT_ZERO
        && !state.timer_control[pit_timer_pkg::CTRL_ZD_BIT]
        |=> state.count == $past(state.preload_value))
        else $error("Counter did not reload after zero.");

    a_rollover_zero : assert property (
        run && tick && !state.load_pending && state.count == pit_timer_pkg::COUNT_ZERO
        && state.timer_control[pit_timer_pkg::CTRL_ZD_BIT]
        |=> state.count == pit_timer_pkg::COUNT_ONES)
        else $error("Counter did not roll over.");

    a_square_toggle : assert property (
        zero_hit && enabled && pin_func == pit_timer_pkg::FUNC_SQUARE
        |=> timer_out_pin_out != $past(timer_out_pin_out))
        else $error("Square wave did not toggle.");

    a_square_idle_high : assert property (
        pin_func == pit_timer_pkg::FUNC_SQUARE && !enabled |-> timer_out_pin_out && timer_out_pin_oe_out)
        else $error("Square wave output not high while disabled.");

    a_ack_answered : assert property (
        timer_irq_ack_pin_in && irq_mode && timer_out_pin_out
        && state.timer_control[pit_timer_pkg::CTRL_TACK_BIT]
        |=> transfer_acknowledge_out && ack_vector_out == $past(state.vector))
        else $error("Asserted request not acknowledged with vector.");

    a_ack_refused : assert property (
        !(irq_mode && state.zero_detect_flag) |=> !transfer_acknowledge_out)
        else $error("Acknowledge given without a request.");

    a_clear_wins : assert property (status_clear |=> !state.zero_detect_flag)
        else $error("Status clear did not win.");

    a_watchdog_halt : assert property (
        enabled && clk_sel == pit_timer_pkg::CLK_GATED && !timer_ext_input_pin_in
        |=> !state.zero_detect_flag && $stable(state.count))
        else $error("Watchdog halt did not clear flag or stop count.");

    a_first_tick_load : assert property (run && tick && state.load_pending
        |=> state.count == $past(state.preload_value) && !state.load_pending)
        else $error("First tick did not load the preload value.");
endmodule

// ===== pit_far_end.sv
// External circuitry model: pulse source on the timer input and pull-up on the shared pin.
`timescale 1ns/100ps
module pit_far_end
(
    input  wire logic clock_in,
    input  wire logic pulse_in,
    input  wire logic hold_in,
    input  wire logic pin_out_in,
    input  wire logic pin_oe_in,
    output logic      ext_out,
    output logic      pin_level_out
);
    logic [2:0] div = 3'h0;
    always @(posedge clock_in)
    begin
        div <= div + 3'h1;
    end
    // Pulses run at one eighth of the clock, slower than the one edge per two clocks the counter input accepts.
    assign ext_out       = hold_in | (pulse_in & div[2]);
    assign pin_level_out = pin_oe_in ? pin_out_in : 1'b1;
endmodule

// ===== pit_timer_bench.sv
// Self-checking bench for the timer block over its register bus and pins.
`timescale 1ns/100ps
module pit_timer_bench;
    logic        clock_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic        s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
    logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, pulse, hold;
    logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, ack_vector_out;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
    logic [3:0]  s_axi_wstrb_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rs;
    logic        timer_ext_input_pin_in, timer_out_pin_in, timer_out_pin_out, timer_out_pin_oe_out;
    logic        timer_irq_ack_pin_in, transfer_acknowledge_out;
    int          n_errors, checks, cyc;
    pit_timer dut (.*);
    pit_far_end far (.clock_in, .pulse_in(pulse), .hold_in(hold), .pin_out_in(timer_out_pin_out),
        .pin_oe_in(timer_out_pin_oe_out), .ext_out(timer_ext_input_pin_in), .pin_level_out(timer_out_pin_in));
    initial
    begin
        clock_in = 0;
        forever #5 clock_in = ~clock_in;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 0;
        dd = 0;
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= d;
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in  <= 1;
        s_axi_bready_in  <= 1;
        while (!(ad && dd))
        begin
            @(posedge clock_in);
            ad = ad | s_axi_awready_out;
            dd = dd | s_axi_wready_out;
            s_axi_awvalid_in <= !ad;
            s_axi_wvalid_in  <= !dd;
        end
        do @(posedge clock_in); while (!s_axi_bvalid_out);
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in  <= 1;
        do @(posedge clock_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 0;
        do @(posedge clock_in); while (!s_axi_rvalid_out);
        rd = s_axi_rdata_out;
        rs = s_axi_rresp_out;
        chk(n, e, rd);
    endtask
    // Waits a bounded time for the pin to reach a level, then compares it.
    task waitpin(input logic v, input int lim);
        repeat (lim) if (timer_out_pin_out !== v) @(posedge clock_in);
        chk("pin", {31'h0, v}, {31'h0, timer_out_pin_out});
    endtask
    task ack(input logic e);
        timer_irq_ack_pin_in <= 1;
        repeat (2) @(posedge clock_in);
        chk("ack", {31'h0, e}, {31'h0, transfer_acknowledge_out});
        chk("vector", e ? {24'h0, pit_timer_pkg::VECTOR_RESET} : 32'h0, {24'h0, ack_vector_out});
        timer_irq_ack_pin_in <= 0;
        @(posedge clock_in);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial
    begin
        {rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, pulse, hold} = 0;
        {s_axi_arvalid_in, s_axi_rready_in, timer_irq_ack_pin_in, s_axi_awaddr_in, s_axi_araddr_in} = 0;
        s_axi_wdata_in = 0;
        s_axi_wstrb_in = 4'hF;
        repeat (12) @(posedge clock_in);
        rst_b_in <= 1;
        @(posedge clock_in);
        rchk("ctrl", 8'h00, 32'h0);
        chk("oe", 32'h0, {31'h0, timer_out_pin_oe_out});
        rchk("portc", 8'h14, 32'h08);
        rchk("unmapped", 8'h1C, 32'h0);
        chk("rresp", {30'h0, pit_timer_pkg::RESP_SLVERR}, {30'h0, rs});
        $display("reset test done");
        wr(8'h08, 32'h2);
        wr(8'h00, 32'hA1);
        waitpin(1, 200);
        rchk("status", 8'h04, 32'h1);
        rchk("portc", 8'h14, 32'h08);
        ack(1);
        wr(8'h04, 32'h1);
        waitpin(0, 4);
        rchk("portc", 8'h14, 32'h0);
        waitpin(1, 200);
        wr(8'h04, 32'h1);
        $display("periodic test done");
        wr(8'h00, 32'h60);
        waitpin(1, 4);
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h61);
        waitpin(0, 200);
        ack(0);
        waitpin(1, 200);
        $display("square test done");
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h93);
        hold <= 1;
        repeat (40) @(posedge clock_in);
        hold <= 0;
        waitpin(0, 1);
        rchk("status", 8'h04, 32'h0);
        hold <= 1;
        waitpin(1, 200);
        rchk("status", 8'h04, 32'h1);
        repeat (32) @(posedge clock_in);
        hold <= 0;
        waitpin(0, 3);
        rchk("status", 8'h04, 32'h0);
        rchk("count", 8'h0C, 32'hFFFFFF);
        $display("watchdog test done");
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h07);
        pulse <= 1;
        repeat (60) @(posedge clock_in);
        pulse <= 0;
        rchk("status", 8'h04, 32'h1);
        wr(8'h00, 32'h06);
        $display("event count test done");
        pulse <= 1;
        wr(8'h00, 32'h85);
        waitpin(1, 1100);
        $display("prescaled input test done");
        tally_and_finish;
    end
endmodule
